// file: include/spo_pkg.sv
package spo_pkg;
    // Serial frame layout: one direction bit, address, data
    localparam int             SPI_ADDR_W     = 15;
    localparam int             SPI_DATA_W     = 8;
    localparam logic [4:0]     SPI_ADDR_LAST  = 5'h0F;   // Count at the last address bit
    localparam logic [4:0]     SPI_FRAME_LAST = 5'h17;   // Count at the last data bit
    localparam logic [4:0]     SPI_FRAME_LEN  = 5'h18;   // Count once the frame is full

    // Register offsets
    localparam logic [14:0]    ADDR_OVERRIDE  = 15'h0058;
    localparam logic [14:0]    ADDR_TRIM      = 15'h0059;
    localparam logic [14:0]    ADDR_PROG_RST  = 15'h005C;
    localparam logic [14:0]    ADDR_CAL_CTRL  = 15'h005D;
    localparam logic [14:0]    ADDR_CAL_STAT  = 15'h005E;

    // Override register fields
    localparam int             OVR_SEL_BIT    = 7;
    localparam int             OVR_SECOND_LSB = 4;
    localparam int             OVR_FIRST_LSB  = 2;
    localparam int             OVR_SE_BIT     = 1;
    localparam int             OVR_EN_BIT     = 0;

    // Other register fields
    localparam int             TRIM_W         = 7;
    localparam int             PROG_RST_BIT   = 0;
    localparam int             CAL_EN_BIT     = 0;
    localparam int             CAL_SETTLE_LSB = 4;
    localparam int             CAL_DONE_BIT   = 0;

    // Reset values
    localparam logic [7:0]     OVERRIDE_RST   = 8'h00;
    localparam logic [6:0]     TRIM_RST       = 7'h00;
    localparam logic           PROG_RST_RST   = 1'b0;
    localparam logic           CAL_EN_RST     = 1'b0;
    localparam logic [2:0]     CAL_SETTLE_RST = 3'h4;

    // Divided-reference output functions
    typedef enum logic [1:0] {
        SPO_REF_OFF  = 2'h0,
        SPO_REF_DIV1 = 2'h1,
        SPO_REF_DIV2 = 2'h2,
        SPO_REF_DIV4 = 2'h3
    } spo_ref_mode_t;
endpackage

// file: hw/spo_spi_slave.sv
`timescale 1ns/100ps
`default_nettype none
// Serial register port: 24-bit frames, MSB first, read flag first
module spo_spi_slave
    import spo_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // Serial pins
    input  wire logic                  sclk,
    input  wire logic                  cs_n,
    input  wire logic                  sdi,
    output logic                       sdo,
    output logic                       sdo_oe,
    // Register side
    output logic [SPI_ADDR_W-1:0]      reg_addr,
    output logic [SPI_DATA_W-1:0]      reg_wdata,
    output logic                       reg_we,
    output logic                       reg_re,
    input  wire logic [SPI_DATA_W-1:0] reg_rdata
);
    logic        sclk_m_q, sclk_s_q, sclk_d_q;   // Clock synchroniser and edge history
    logic        cs_m_q, cs_s_q;                 // Select synchroniser
    logic        sdi_m_q, sdi_s_q;               // Data synchroniser
    logic [22:0] rx_q;                           // Received bits so far
    logic [4:0]  cnt_q;                          // Bits received in this frame
    logic        read_q;                         // Frame is a read
    logic        load_q;                         // Read data due for the shifter
    logic [7:0]  tx_q;                           // Outgoing read data
    logic        rise, fall, data_phase;

    assign rise       = sclk_s_q & ~sclk_d_q;
    assign fall       = ~sclk_s_q & sclk_d_q;
    assign data_phase = read_q && (cnt_q > SPI_ADDR_LAST);

    // Pins are asynchronous, so each passes two flops
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sclk_m_q <= 1'b0;
            sclk_s_q <= 1'b0;
            sclk_d_q <= 1'b0;
            cs_m_q   <= 1'b1;
            cs_s_q   <= 1'b1;
            sdi_m_q  <= 1'b0;
            sdi_s_q  <= 1'b0;
        end
        else
        begin
            sclk_m_q <= sclk;
            sclk_s_q <= sclk_m_q;
            sclk_d_q <= sclk_s_q;
            cs_m_q   <= cs_n;
            cs_s_q   <= cs_m_q;
            sdi_m_q  <= sdi;
            sdi_s_q  <= sdi_m_q;
        end
    end

    // Receive shifter, bit count and request strobes
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_q      <= '0;
            cnt_q     <= '0;
            read_q    <= 1'b0;
            reg_addr  <= '0;
            reg_wdata <= '0;
            reg_we    <= 1'b0;
            reg_re    <= 1'b0;
        end
        else
        begin
            reg_we <= 1'b0;
            reg_re <= 1'b0;
            if (cs_s_q)
            begin
                // Deselect aborts a partial frame
                cnt_q  <= '0;
                read_q <= 1'b0;
            end
            else if (rise && cnt_q != SPI_FRAME_LEN)
            begin
                rx_q  <= {rx_q[21:0], sdi_s_q};
                cnt_q <= cnt_q + 5'h01;
                if (cnt_q == SPI_ADDR_LAST)
                begin
                    reg_addr <= {rx_q[13:0], sdi_s_q};
                    read_q   <= rx_q[14];
                    reg_re   <= rx_q[14];
                end
                // Writes land only once all eight data bits are in
                if (cnt_q == SPI_FRAME_LAST && !read_q)
                begin
                    reg_wdata <= {rx_q[6:0], sdi_s_q};
                    reg_we    <= 1'b1;
                end
            end
        end
    end

    // Transmit shifter, changes on falling serial clock edges
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            load_q <= 1'b0;
            tx_q   <= '0;
            sdo    <= 1'b0;
            sdo_oe <= 1'b0;
        end
        else
        begin
            load_q <= reg_re;
            sdo_oe <= !cs_s_q && data_phase;
            if (load_q)
                tx_q <= reg_rdata;
            else if (fall && data_phase && !cs_s_q)
            begin
                sdo  <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end
endmodule
`default_nettype wire

// file: hw/spo_synth_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Bit 7 chooses straps or registers
// - Bits 5:4 set second output divide
// - Second output silent unless first runs
// - Bits 3:2 set first output divide
// - Pin mode: straps set both outputs
// - Bit 1 selects single-ended reference input
// - Bit 0 enables synthesizer in register mode
// - Seven-bit trim, calibration may overwrite
// - Tuned trim readable and rewritable
// - Clearing program reset starts enabled calibration
// - Done flag after finish or skip
module spo_synth_ctrl
    import spo_pkg::*;
#(
    parameter int TRIM_BITS = TRIM_W
)
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // Serial register pins
    input  wire logic                  sclk,
    input  wire logic                  cs_n,
    input  wire logic                  sdi,
    output logic                       sdo,
    output logic                       sdo_oe,
    // Strap pins
    input  wire logic                  synth_enable_pin,
    input  wire logic                  single_ended_ref_pin,
    input  wire logic                  clock_config_strap0,
    input  wire logic                  clock_config_strap1,
    // Calibration engine
    input  wire logic                  cal_trim_we,
    input  wire logic [TRIM_BITS-1:0]  cal_trim_value,
    input  wire logic                  cal_finish,
    output logic                       cal_start,
    output logic                       oscillator_cal_enable,
    output logic [2:0]                 cal_settle,
    // Synthesizer controls
    output logic                       synth_enable,
    output logic                       single_ended_ref_input,
    output logic [1:0]                 first_ref_clock_out,
    output logic [1:0]                 second_ref_clock_out,
    output logic [TRIM_BITS-1:0]       oscillator_frequency_trim,
    output logic                       synth_program_reset
);
    if (TRIM_BITS != TRIM_W)
        $error("TRIM_BITS must be 7");

    logic [SPI_ADDR_W-1:0] reg_addr;        // Current frame address
    logic [SPI_DATA_W-1:0] reg_wdata;       // Write data
    logic                  reg_we, reg_re;  // Request strobes
    logic [SPI_DATA_W-1:0] rdata;           // Read mux

    logic       register_control_select_q;  // Override select
    logic [1:0] second_ref_output_select_q; // Second output field
    logic [1:0] first_ref_output_select_q;  // First output field
    logic       single_ended_ref_override_q;
    logic       synth_enable_override_q;
    logic       cal_done_q;                 // Calibration finished or skipped

    logic [3:0] strap_m_q, strap_s_q;       // Strap synchroniser
    logic [1:0] eff_first_d, eff_second_d, strap_first, strap_second;
    logic       eff_en_d, eff_se_d, prog_clear;

    spo_spi_slave u_spi (
        .clk       (clk),
        .resetn    (resetn),
        .sclk      (sclk),
        .cs_n      (cs_n),
        .sdi       (sdi),
        .sdo       (sdo),
        .sdo_oe    (sdo_oe),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_we    (reg_we),
        .reg_re    (reg_re),
        .reg_rdata (rdata)
    );

    // Write that drops the program reset bit from one to zero
    assign prog_clear = reg_we && reg_addr == ADDR_PROG_RST && !reg_wdata[PROG_RST_BIT] && synth_program_reset;

    // Straps are asynchronous levels
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            strap_m_q <= '0;
            strap_s_q <= '0;
        end
        else
        begin
            strap_m_q <= {clock_config_strap1, clock_config_strap0, single_ended_ref_pin, synth_enable_pin};
            strap_s_q <= strap_m_q;
        end
    end

    // Strap decode of the two reference outputs
    always_comb
    begin
        case (strap_s_q[3:2])
            2'h0:
            begin
                strap_first  = SPO_REF_OFF;
                strap_second = SPO_REF_OFF;
            end
            2'h1:
            begin
                strap_first  = SPO_REF_DIV1;
                strap_second = SPO_REF_OFF;
            end
            2'h2:
            begin
                strap_first  = SPO_REF_DIV2;
                strap_second = SPO_REF_DIV2;
            end
            default:
            begin
                strap_first  = SPO_REF_DIV4;
                strap_second = SPO_REF_DIV4;
            end
        endcase
    end

    // Source selection between straps and register fields
    always_comb
    begin
        if (register_control_select_q)
        begin
            eff_first_d  = first_ref_output_select_q;
            eff_second_d = second_ref_output_select_q;
            eff_en_d     = synth_enable_override_q;
            eff_se_d     = single_ended_ref_override_q;
        end
        else
        begin
            eff_first_d  = strap_first;
            eff_second_d = strap_second;
            eff_en_d     = strap_s_q[0];
            eff_se_d     = strap_s_q[1];
        end
        // Second divider rides on the first one
        if (eff_first_d == SPO_REF_OFF)
            eff_second_d = SPO_REF_OFF;
    end

    // Registered synthesizer controls
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            synth_enable           <= 1'b0;
            single_ended_ref_input <= 1'b0;
            first_ref_clock_out    <= SPO_REF_OFF;
            second_ref_clock_out   <= SPO_REF_OFF;
        end
        else
        begin
            synth_enable           <= eff_en_d;
            single_ended_ref_input <= eff_se_d;
            first_ref_clock_out    <= eff_first_d;
            second_ref_clock_out   <= eff_second_d;
        end
    end

    // Override register; reserved bit is not stored
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            register_control_select_q   <= OVERRIDE_RST[OVR_SEL_BIT];
            second_ref_output_select_q  <= OVERRIDE_RST[OVR_SECOND_LSB +: 2];
            first_ref_output_select_q   <= OVERRIDE_RST[OVR_FIRST_LSB +: 2];
            single_ended_ref_override_q <= OVERRIDE_RST[OVR_SE_BIT];
            synth_enable_override_q     <= OVERRIDE_RST[OVR_EN_BIT];
        end
        else if (reg_we && reg_addr == ADDR_OVERRIDE)
        begin
            register_control_select_q   <= reg_wdata[OVR_SEL_BIT];
            second_ref_output_select_q  <= reg_wdata[OVR_SECOND_LSB +: 2];
            first_ref_output_select_q   <= reg_wdata[OVR_FIRST_LSB +: 2];
            single_ended_ref_override_q <= reg_wdata[OVR_SE_BIT];
            synth_enable_override_q     <= reg_wdata[OVR_EN_BIT];
        end
    end

    // Trim: the engine wins a same-cycle clash, register writes still land while it tunes
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            oscillator_frequency_trim <= TRIM_RST;
        else if (cal_trim_we)
            oscillator_frequency_trim <= cal_trim_value;
        else if (reg_we && reg_addr == ADDR_TRIM)
            oscillator_frequency_trim <= reg_wdata[TRIM_BITS-1:0];
    end

    // Program reset and calibration control
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            synth_program_reset   <= PROG_RST_RST;
            oscillator_cal_enable <= CAL_EN_RST;
            cal_settle            <= CAL_SETTLE_RST;
            cal_start             <= 1'b0;
        end
        else
        begin
            cal_start <= prog_clear && oscillator_cal_enable;
            if (reg_we && reg_addr == ADDR_PROG_RST)
                synth_program_reset <= reg_wdata[PROG_RST_BIT];
            if (reg_we && reg_addr == ADDR_CAL_CTRL)
            begin
                oscillator_cal_enable <= reg_wdata[CAL_EN_BIT];
                cal_settle            <= reg_wdata[CAL_SETTLE_LSB +: 3];
            end
        end
    end

    // Done flag: a finish in the clearing cycle still sets it
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            cal_done_q <= 1'b0;
        else if (cal_finish || (prog_clear && !oscillator_cal_enable))
            cal_done_q <= 1'b1;
        else if (reg_we && reg_addr == ADDR_PROG_RST && reg_wdata[PROG_RST_BIT])
            cal_done_q <= 1'b0;
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        case (reg_addr)
            ADDR_OVERRIDE: rdata = {register_control_select_q, 1'b0, second_ref_output_select_q,
                                    first_ref_output_select_q, single_ended_ref_override_q,
                                    synth_enable_override_q};
            ADDR_TRIM:     rdata = {1'b0, oscillator_frequency_trim};
            ADDR_PROG_RST: rdata = {7'h00, synth_program_reset};
            ADDR_CAL_CTRL: rdata = {1'b0, cal_settle, 3'h0, oscillator_cal_enable};
            ADDR_CAL_STAT: rdata = {7'h00, cal_done_q};
            default:       rdata = 8'h00;
        endcase
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_clear_enabled;
        prog_clear && oscillator_cal_enable;
    endsequence
    sequence s_start_pulse;
        cal_start ##1 !cal_start;
    endsequence

    a_pin_mode_enable: assert property (!register_control_select_q |=> synth_enable == $past(strap_s_q[0]))
        else $error("Pin mode enable does not follow strap");
    a_second_select: assert property (register_control_select_q && first_ref_output_select_q != 2'h0
        |=> second_ref_clock_out == $past(second_ref_output_select_q))
        else $error("Second output ignores its field");
    a_second_gated: assert property (second_ref_clock_out != 2'h0 |-> first_ref_clock_out != 2'h0)
        else $error("Second output runs without first");
    a_first_select: assert property (register_control_select_q
        |=> first_ref_clock_out == $past(first_ref_output_select_q))
        else $error("First output ignores its field");
    a_strap_outputs: assert property (!register_control_select_q |=> first_ref_clock_out == $past(strap_first))
        else $error("Pin mode first output not from straps");
    a_se_override: assert property (register_control_select_q
        |=> single_ended_ref_input == $past(single_ended_ref_override_q))
        else $error("Single-ended select ignores register");
    a_enable_override: assert property (register_control_select_q
        |=> synth_enable == $past(synth_enable_override_q))
        else $error("Enable ignores register");
    a_trim_engine: assert property (cal_trim_we |=> oscillator_frequency_trim == $past(cal_trim_value))
        else $error("Engine trim not taken");
    a_trim_readback: assert property (reg_re && reg_addr == ADDR_TRIM
        |-> rdata == {1'b0, oscillator_frequency_trim})
        else $error("Trim read does not return field");
    a_cal_start: assert property (s_clear_enabled |=> s_start_pulse)
        else $error("Calibration start missing or long");
    a_done_skip: assert property (prog_clear && !oscillator_cal_enable |=> cal_done_q [*2])
        else $error("Skipped calibration not flagged done");
endmodule
`default_nettype wire

// file: testbench/spo_cal_engine_model.sv
`timescale 1ns/100ps
`default_nettype none
// Calibration engine stand-in: tunes the trim after each start pulse
module spo_cal_engine_model
    import spo_pkg::*;
#(
    parameter int         RUN_CYCLES = 20,    // Tuning time, far shorter than silicon
    parameter logic [6:0] TUNED_TRIM = 7'h2A  // Result the run settles on
)
(
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  resetn,
    // Block side
    input  wire logic  cal_start,
    output logic       cal_trim_we,
    output logic [6:0] cal_trim_value,
    output logic       cal_finish
);
    int count_q;  // Cycles left in the run, 0 when idle

    // Run counter; result written one cycle before done is reported
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count_q     <= 0;
            cal_trim_we <= 1'b0;
            cal_finish  <= 1'b0;
        end
        else
        begin
            cal_trim_we <= (count_q == 2);
            cal_finish  <= (count_q == 1);
            if (cal_start)
                count_q <= RUN_CYCLES;
            else if (count_q > 0)
                count_q <= count_q - 1;
        end
    end

    // Value only meaningful with the strobe; otherwise show its inverse
    assign cal_trim_value = cal_trim_we ? TUNED_TRIM : ~TUNED_TRIM;
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the synthesizer override registers
module tb_top;
    import spo_pkg::*;

    localparam logic [6:0] TUNED = 7'h15;  // Engine result, arbitrary
    logic       clk, resetn, sclk, cs_n, sdi, sdo, sdo_oe;
    logic       en_pin, se_pin, strap0, strap1;  // Strap pins
    logic       cal_trim_we, cal_finish, cal_start, cal_en, synth_en, se_in, prog_rst;
    logic [6:0] cal_trim_value, trim;
    logic [2:0] cal_settle;
    logic [1:0] first_out, second_out;
    logic [7:0] rd;
    logic       oe_rd;  // Pin driven at every read-data sample
    int         error_cnt, n_compared, starts;

    spo_synth_ctrl dut (.clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe), .synth_enable_pin(en_pin), .single_ended_ref_pin(se_pin),
        .clock_config_strap0(strap0), .clock_config_strap1(strap1), .cal_trim_we(cal_trim_we),
        .cal_trim_value(cal_trim_value), .cal_finish(cal_finish), .cal_start(cal_start),
        .oscillator_cal_enable(cal_en), .cal_settle(cal_settle), .synth_enable(synth_en),
        .single_ended_ref_input(se_in), .first_ref_clock_out(first_out),
        .second_ref_clock_out(second_out), .oscillator_frequency_trim(trim),
        .synth_program_reset(prog_rst));
    spo_cal_engine_model #(.TUNED_TRIM(TUNED)) eng (.clk(clk), .resetn(resetn), .cal_start(cal_start),
        .cal_trim_we(cal_trim_we), .cal_trim_value(cal_trim_value), .cal_finish(cal_finish));

    // 100 ns clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Start pulses seen, to tell a run from a skip
    always @(posedge clk)
        if (cal_start === 1'b1)
            starts++;

    task automatic tally_and_finish();
        if (error_cnt == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One frame; phases of 8 clocks keep the synchroniser margin
    task automatic spi_xfer(input logic rnw, input logic [14:0] addr, input logic [7:0] wd);
        logic [23:0] frame;
        frame = {rnw, addr, wd};
        rd = 8'h00;
        oe_rd = 1'b1;
        cs_n = 1'b0;
        repeat (8) @(negedge clk);
        for (int i = 23; i >= 0; i--)
        begin
            sdi = frame[i];
            repeat (8) @(negedge clk);
            sclk = 1'b1;
            if (i < 8)
            begin
                rd = {rd[6:0], sdo};
                oe_rd = oe_rd & sdo_oe;
            end
            repeat (8) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (8) @(negedge clk);
        cs_n = 1'b1;
        sdi = ~sdi;  // Released line must not keep the last bit
        repeat (10) @(negedge clk);
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        spi_xfer(1'b0, a, d);
    endtask

    task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
        spi_xfer(1'b1, a, 8'h00);
        chk(rd, exp);
        chk({6'h00, oe_rd, sdo_oe}, 8'h02);
    endtask

    // Override outputs packed for one compare
    function automatic logic [7:0] outs();
        return {2'b00, synth_en, se_in, first_out, second_out};
    endfunction

    task automatic t_reset_values();
        rd_chk(ADDR_OVERRIDE, 8'h00);
        rd_chk(ADDR_TRIM, 8'h00);
        rd_chk(ADDR_PROG_RST, 8'h00);
        rd_chk(ADDR_CAL_CTRL, 8'h40);
        rd_chk(ADDR_CAL_STAT, 8'h00);
        rd_chk(15'h0060, 8'h00);       // Unmapped place
        chk({5'h00, cal_settle}, 8'h04);
        chk({7'h00, prog_rst}, 8'h00);
    endtask

    // Pin mode: straps decide everything
    task automatic t_pin_mode();
        logic [1:0] f, s;
        for (int v = 0; v < 16; v++)
        begin
            {en_pin, se_pin, strap1, strap0} = v[3:0];
            repeat (6) @(negedge clk);
            f = {strap1, strap0};
            s = (f == 2'h1) ? 2'h0 : f;
            chk(outs(), {2'b00, en_pin, se_pin, f, s});
        end
    endtask

    // Register mode: every field pair, straps held at the opposite meaning
    task automatic t_reg_mode();
        logic [7:0] w;
        logic [1:0] f, s;
        {en_pin, se_pin, strap1, strap0} = 4'hF;
        for (int v = 0; v < 16; v++)
        begin
            f = v[1:0];
            s = v[3:2];
            w = {1'b1, 1'b0, s, f, v[0], v[2]};
            wr(ADDR_OVERRIDE, w);
            chk(outs(), {2'b00, v[2], v[0], f, (f == 2'h0) ? 2'h0 : s});
            rd_chk(ADDR_OVERRIDE, w);
        end
        wr(ADDR_OVERRIDE, 8'h00);
        chk(outs(), {2'b00, 1'b1, 1'b1, 2'h3, 2'h3});
    endtask

    // Calibration run, trim handed over, then a skipped calibration
    task automatic t_calibration();
        int s0;
        wr(ADDR_PROG_RST, 8'h01);
        chk({7'h00, prog_rst}, 8'h01);
        wr(ADDR_TRIM, 8'h55);
        rd_chk(ADDR_TRIM, 8'h55);
        chk({1'b0, trim}, 8'h55);
        wr(ADDR_CAL_CTRL, 8'h31);
        chk({7'h00, cal_en}, 8'h01);
        chk({5'h00, cal_settle}, 8'h03);
        rd_chk(ADDR_CAL_CTRL, 8'h31);
        s0 = starts;
        wr(ADDR_PROG_RST, 8'h00);
        repeat (40) @(negedge clk);
        chk(8'(starts - s0), 8'h01);
        rd_chk(ADDR_CAL_STAT, 8'h01);
        rd_chk(ADDR_TRIM, {1'b0, TUNED});
        wr(ADDR_TRIM, 8'h33);
        rd_chk(ADDR_TRIM, 8'h33);
        chk({1'b0, trim}, 8'h33);
        wr(ADDR_PROG_RST, 8'h01);
        rd_chk(ADDR_CAL_STAT, 8'h00);
        wr(ADDR_CAL_CTRL, 8'h40);
        rd_chk(ADDR_CAL_CTRL, 8'h40);
        s0 = starts;
        wr(ADDR_PROG_RST, 8'h00);
        rd_chk(ADDR_CAL_STAT, 8'h01);
        chk(8'(starts - s0), 8'h00);
        rd_chk(ADDR_TRIM, 8'h33);
    endtask

    // Second reset in mid-run must bring every register back
    task automatic t_mid_reset();
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        t_reset_values();
    endtask

    // Main sequence
    initial
    begin
        error_cnt = 0;
        n_compared = 0;
        starts = 0;
        resetn = 1'b0;
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
        {en_pin, se_pin, strap1, strap0} = 4'h0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        t_reset_values();
        t_pin_mode();
        t_reg_mode();
        t_calibration();
        t_mid_reset();
        tally_and_finish();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (80000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
